// ==== modbus_register_server.sv ====
`timescale 1ns/1ps
module modbus_register_server import modbus_pkg::*; #(
	parameter int BUF_DEPTH = 256,
	parameter int SILENCE_CYC = SILENCE_CYCLES,
	parameter int MS_CYC = MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] unit_addr,
	input wire logic [7:0] ser_rx_data,
	input wire logic ser_rx_valid,
	output logic [7:0] ser_tx_data,
	output logic ser_tx_valid,
	input wire logic ser_tx_ready,
	input wire logic [7:0] usb_rx_data,
	input wire logic usb_rx_valid,
	output logic [7:0] usb_tx_data,
	output logic usb_tx_valid,
	input wire logic usb_tx_ready,
	input wire logic det_new,
	input wire logic [15:0] segment_count,
	input wire logic [15:0] detection_count,
	input wire logic [15:0] light_power_percent,
	output logic [15:0] map_addr,
	input wire logic [15:0] map_data,
	input wire logic exec_fail,
	output logic [15:0] accumulation_exponent,
	output logic [15:0] oversampling_exponent,
	output logic [15:0] base_sample_count,
	output logic [15:0] detection_threshold
);
	localparam int AW = $clog2(BUF_DEPTH);

	// ------------------------------------------------------------------------
	// state and storage
	// ------------------------------------------------------------------------
	srv_state_t state_q;
	logic sel_q;
	logic [7:0] buf_q [0:BUF_DEPTH-1];
	logic [AW:0] len_q;
	logic ovf_q;
	logic [15:0] rx_crc_q;
	logic [15:0] tx_crc_q;
	logic [15:0] gap_q;
	logic [15:0] hold_q [0:HR_COUNT-1];
	logic ready_q;
	logic [31:0] ts_q;
	logic [15:0] ms_div_q;
	logic [7:0] exc_q;
	logic rd_resp_q;
	logic input_q;
	logic [2:0] hdr_idx_q;
	logic [2:0] hdr_len_q;
	logic [15:0] rd_addr_q;
	logic [7:0] rd_cnt_q;
	logic [15:0] word_q;
	logic [15:0] map_addr_q;
	logic [7:0] tx_data_q;
	logic tx_valid_q;

	// ------------------------------------------------------------------------
	// port selection and byte intake
	// ------------------------------------------------------------------------
	// in idle the serial port wins a tie; afterwards the chosen port is held
	wire logic idle_w = (state_q == ST_IDLE);
	wire logic src_w = idle_w ? (~ser_rx_valid & usb_rx_valid) : sel_q;
	wire logic in_valid = src_w ? usb_rx_valid : ser_rx_valid;
	wire logic [7:0] in_byte = src_w ? usb_rx_data : ser_rx_data;
	wire logic rx_take = in_valid & (idle_w | state_q == ST_RECV);
	wire logic gap_end = (gap_q == 16'(SILENCE_CYC - 1)) & ~rx_take;
	wire logic tx_ready_w = sel_q ? usb_tx_ready : ser_tx_ready;
	wire logic tx_free = ~tx_valid_q | tx_ready_w;

	// ------------------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------------------
	wire logic [7:0] fc = buf_q[1];
	wire logic [15:0] start_a = {buf_q[2], buf_q[3]};
	wire logic [15:0] qty_a = {buf_q[4], buf_q[5]};
	wire logic [15:0] ws17 = {buf_q[6], buf_q[7]};
	wire logic [15:0] wq17 = {buf_q[8], buf_q[9]};
	wire logic f_rh = (fc == FC_RD_HOLD);
	wire logic f_ri = (fc == FC_RD_INPUT);
	wire logic f_w1 = (fc == FC_WR_ONE);
	wire logic f_wm = (fc == FC_WR_MULTI);
	wire logic f_rw = (fc == FC_RW_MULTI);
	wire logic f_known = f_rh | f_ri | f_w1 | f_wm | f_rw;
	wire logic f_read = f_rh | f_ri | f_rw;
	wire logic f_write = f_w1 | f_wm | f_rw;
	wire logic [7:0] bcnt = f_rw ? buf_q[10] : buf_q[6];
	wire logic [AW:0] need_len = f_wm ? (AW+1)'(9 + bcnt)
		: f_rw ? (AW+1)'(13 + bcnt) : (AW+1)'(8);
	wire logic is_bcast = (buf_q[0] == UNIT_BCAST);
	// crc residue of zero means the check bytes matched
	wire logic frame_ok = (rx_crc_q == 16'h0000) & ~ovf_q
		& (len_q == need_len) & (is_bcast | buf_q[0] == unit_addr);
	wire logic [15:0] ws = f_rw ? ws17 : start_a;
	wire logic [15:0] wq = f_rw ? wq17 : (f_w1 ? 16'h0001 : qty_a);
	wire logic [16:0] rd_end = {1'b0, start_a} + {1'b0, qty_a} - 17'h00001;
	wire logic [16:0] wr_end = {1'b0, ws} + {1'b0, wq} - 17'h00001;
	wire logic [20:0] in_last = 21'(IR_ARRAY) + 21'(ARRAYS_PER_SEG)
		* 21'(segment_count) - 21'h000001;
	wire logic rd_qty_bad = f_read & (qty_a == 16'h0000 | qty_a > MAX_RD_QTY);
	wire logic wr_qty_bad = (f_wm & (wq == 16'h0000 | wq > MAX_WR_QTY))
		| (f_rw & (wq == 16'h0000 | wq > MAX_RW_QTY))
		| ((f_wm | f_rw) & ({8'h00, bcnt} != {wq[14:0], 1'b0}));
	// an input block must lie wholly in 1..2 or wholly in 11..last
	wire logic in_rng_ok = (start_a >= IR_READY & rd_end <= 17'(IR_SEGS))
		| (start_a >= IR_DET_COUNT & {4'h0, rd_end} <= in_last);
	wire logic rd_rng_ok = f_ri ? in_rng_ok : (rd_end <= 17'(HR_LAST));
	wire logic wr_rng_ok = ~f_write | (wr_end <= 17'(HR_LAST));
	wire logic [7:0] exc_w = ~f_known ? EXC_FUNC
		: (rd_qty_bad | wr_qty_bad) ? EXC_VALUE
		: ((f_read & ~rd_rng_ok) | ~wr_rng_ok) ? EXC_ADDR
		: exec_fail ? EXC_FAIL : 8'h00;
	wire logic do_write = (state_q == ST_EXEC) & frame_ok & f_write
		& (exc_w == 8'h00);

	// ------------------------------------------------------------------------
	// word fetch for read answers
	// ------------------------------------------------------------------------
	wire logic [15:0] seg_off = rd_addr_q - IR_ARRAY;
	wire logic [17:0] seg3 = (segment_count == 16'h0000) ? 18'h00001
		: 18'(segment_count) * 18'h00003;
	wire logic [17:0] seg_rem = 18'(seg_off) % seg3;
	wire logic is_flag = seg_rem >= {1'b0, segment_count, 1'b0};
	// flag words force valid and drop reserved low bits
	wire logic [15:0] arr_word = is_flag
		? ((map_data & FLAG_KEEP) | FLAG_VALID) : map_data;
	wire logic [15:0] in_word = (rd_addr_q == IR_READY) ? {15'h0000, ready_q}
		: (rd_addr_q == IR_SEGS) ? segment_count
		: (rd_addr_q == IR_DET_COUNT) ? detection_count
		: (rd_addr_q == IR_LIGHT) ? light_power_percent
		: (rd_addr_q == IR_STATUS) ? STATUS_RSVD
		: (rd_addr_q == IR_TS_LO) ? ts_q[15:0]
		: (rd_addr_q == IR_TS_HI) ? ts_q[31:16] : arr_word;
	wire logic [15:0] hold_word = hold_q[rd_addr_q[2:0]];
	wire logic [15:0] fetch_word = input_q ? in_word : hold_word;
	wire logic ready_clr = (state_q == ST_WAIT) & input_q
		& (rd_addr_q == IR_READY) & ready_q;

	// ------------------------------------------------------------------------
	// answer byte selection
	// ------------------------------------------------------------------------
	wire logic [7:0] hdr_byte = (exc_q != 8'h00)
		? ((hdr_idx_q == 3'd0) ? buf_q[0]
		: (hdr_idx_q == 3'd1) ? (buf_q[1] | EXC_MARK) : exc_q)
		: (rd_resp_q & hdr_idx_q == 3'd2) ? {rd_cnt_q[6:0], 1'b0}
		: buf_q[AW'(hdr_idx_q)];
	wire logic emit_st = (state_q == ST_HDR) | (state_q == ST_DHI)
		| (state_q == ST_DLO) | (state_q == ST_CRCL) | (state_q == ST_CRCH);
	wire logic emit = emit_st & tx_free;
	wire logic [7:0] out_byte = (state_q == ST_HDR) ? hdr_byte
		: (state_q == ST_DHI) ? word_q[15:8]
		: (state_q == ST_DLO) ? word_q[7:0]
		: (state_q == ST_CRCL) ? tx_crc_q[7:0] : tx_crc_q[15:8];

	assign ser_tx_data = tx_data_q;
	assign usb_tx_data = tx_data_q;
	assign ser_tx_valid = tx_valid_q & ~sel_q;
	assign usb_tx_valid = tx_valid_q & sel_q;
	assign map_addr = map_addr_q;
	assign accumulation_exponent = hold_q[0];
	assign oversampling_exponent = hold_q[1];
	assign base_sample_count = hold_q[2];
	assign detection_threshold = hold_q[4];

	// ------------------------------------------------------------------------
	// frame capture and silence timing
	// ------------------------------------------------------------------------
	// frame buffer, written only while a frame is collected
	always_ff @(posedge clk) begin
		if (rx_take & ~len_q[AW]) begin
			buf_q[len_q[AW-1:0]] <= in_byte;
		end
	end

	// byte count, overflow and running crc of the request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			len_q <= '0;
			ovf_q <= 1'b0;
			rx_crc_q <= CRC_INIT;
			gap_q <= 16'h0000;
		end else begin
			gap_q <= (rx_take | idle_w) ? 16'h0000 : gap_q + 16'h0001;
			if (idle_w & ~rx_take) begin
				len_q <= '0;
				ovf_q <= 1'b0;
				rx_crc_q <= CRC_INIT;
			end else if (rx_take) begin
				len_q <= len_q[AW] ? len_q : len_q + 1'b1;
				ovf_q <= ovf_q | len_q[AW];
				rx_crc_q <= crc_step(rx_crc_q, in_byte);
			end
		end
	end

	// ------------------------------------------------------------------------
	// holding registers, one per generate entry
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < HR_COUNT; i++) begin : g_hold
		wire logic hit = do_write & (16'(i) >= ws) & (17'(i) <= wr_end);
		wire logic [7:0] rel = 8'(i) - ws[7:0];
		wire logic [7:0] pos = f_w1 ? 8'h04
			: f_wm ? 8'h07 + {rel[6:0], 1'b0} : 8'h0b + {rel[6:0], 1'b0};
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				hold_q[i] <= HR_RST;
			end else if (hit & (16'(i) != HR_RSVD)) begin
				hold_q[i] <= {buf_q[AW'(pos)], buf_q[AW'(pos + 8'h01)]};
			end
		end
	end

	// ------------------------------------------------------------------------
	// detection ready flag and millisecond timestamp
	// ------------------------------------------------------------------------
	// a new detection set in the clearing cycle keeps the flag up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= det_new | (ready_q & ~ready_clr);
		end
	end

	// uptime in milliseconds
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_div_q <= 16'h0000;
			ts_q <= 32'h00000000;
		end else if (ms_div_q == 16'(MS_CYC - 1)) begin
			ms_div_q <= 16'h0000;
			ts_q <= ts_q + 32'h00000001;
		end else begin
			ms_div_q <= ms_div_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------------------
	// transmit byte register and answer crc
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_crc_q <= CRC_INIT;
		end else begin
			if (emit) begin
				tx_data_q <= out_byte;
			end
			tx_valid_q <= emit | (tx_valid_q & ~tx_ready_w);
			if (state_q == ST_EXEC) begin
				tx_crc_q <= CRC_INIT;
			end else if (emit & state_q != ST_CRCL & state_q != ST_CRCH) begin
				tx_crc_q <= crc_step(tx_crc_q, out_byte);
			end
		end
	end

	// ------------------------------------------------------------------------
	// server sequence
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			sel_q <= 1'b0;
			exc_q <= 8'h00;
			rd_resp_q <= 1'b0;
			input_q <= 1'b0;
			hdr_idx_q <= 3'd0;
			hdr_len_q <= 3'd0;
			rd_addr_q <= 16'h0000;
			rd_cnt_q <= 8'h00;
			word_q <= 16'h0000;
			map_addr_q <= 16'h0000;
		end else begin
			unique case (state_q)
				ST_IDLE: if (rx_take) begin
					sel_q <= src_w;
					state_q <= ST_RECV;
				end
				ST_RECV: if (gap_end) begin
					state_q <= ST_EXEC;
				end
				ST_EXEC: begin
					exc_q <= exc_w;
					rd_resp_q <= f_read & (exc_w == 8'h00);
					input_q <= f_ri;
					hdr_idx_q <= 3'd0;
					hdr_len_q <= (exc_w != 8'h00 | f_read) ? 3'd3 : 3'd6;
					rd_addr_q <= start_a;
					rd_cnt_q <= qty_a[7:0];
					state_q <= (frame_ok & ~is_bcast) ? ST_HDR : ST_IDLE;
				end
				ST_HDR: if (emit) begin
					hdr_idx_q <= hdr_idx_q + 3'd1;
					if (hdr_idx_q == hdr_len_q - 3'd1) begin
						state_q <= rd_resp_q ? ST_FETCH : ST_CRCL;
					end
				end
				ST_FETCH: begin
					map_addr_q <= rd_addr_q - IR_ARRAY;
					state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					word_q <= fetch_word;
					state_q <= ST_DHI;
				end
				ST_DHI: if (emit) begin
					state_q <= ST_DLO;
				end
				ST_DLO: if (emit) begin
					rd_addr_q <= rd_addr_q + 16'h0001;
					rd_cnt_q <= rd_cnt_q - 8'h01;
					state_q <= (rd_cnt_q == 8'h01) ? ST_CRCL : ST_FETCH;
				end
				ST_CRCL: if (emit) begin
					state_q <= ST_CRCH;
				end
				ST_CRCH: if (emit) begin
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	a_ready_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
		det_new |=> ready_q) else $error("new detection set lost");
	a_ready_read_clears: assert property (@(posedge clk) disable iff (!rst_b)
		ready_clr & ~det_new |=> ~ready_q ##1 word_q == 16'h0001)
		else $error("ready flag not cleared by read");
	a_ts_tick: assert property (@(posedge clk) disable iff (!rst_b)
		ms_div_q == 16'(MS_CYC - 1) |=> ts_q == $past(ts_q) + 32'h00000001)
		else $error("timestamp did not advance");
	a_flag_valid_bit: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_WAIT & input_q & rd_addr_q >= IR_ARRAY & is_flag
		|=> word_q[0] & ~word_q[2]) else $error("flag word malformed");
	a_word_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_DHI & emit |=> tx_data_q == word_q[15:8])
		else $error("low byte sent first");
	a_bad_frame_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_EXEC & ~frame_ok |=> state_q == ST_IDLE ##1 ~emit)
		else $error("bad frame answered");
	a_bcast_no_reply: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_EXEC & is_bcast |=> state_q == ST_IDLE)
		else $error("broadcast answered");
	a_silence_ends: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_RECV & gap_end |=> state_q == ST_EXEC)
		else $error("frame end missed");
	a_write_one: assert property (@(posedge clk) disable iff (!rst_b)
		do_write & f_w1 & start_a == 16'h0004
		|=> detection_threshold == {$past(buf_q[4]), $past(buf_q[5])})
		else $error("threshold write lost");
	a_exc_addr: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_EXEC & frame_ok & f_rh & ~rd_qty_bad & rd_end > 17'h00004
		|=> exc_q == EXC_ADDR) else $error("missing address exception");
	c_input_read: cover property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_CRCH & emit & input_q & rd_resp_q);
	c_hold_write: cover property (@(posedge clk) disable iff (!rst_b)
		do_write & f_wm);
	c_exception: cover property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_HDR & exc_q != 8'h00 & emit);
	c_usb_answer: cover property (@(posedge clk) disable iff (!rst_b)
		usb_tx_valid & usb_tx_ready);
endmodule : modbus_register_server

// ==== modbus_pkg.sv ====
// ----------------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------------
// Notes on behaviour
// - serial register port uses Modbus RTU framing only, no other mode
// - usb virtual serial port serves the same Modbus requests and answers
// - function 0x04 returns the requested block of detection input words
// - functions 0x03, 0x06, 0x10 and 0x17 serve the configuration words
// - input 1 reads 1 when new detections wait; reading 1 clears it
// - input 2 gives segment count N which sizes every per-segment array
// - input 11 gives detection count, input 12 gives light power percent
// - input 13 is an acquisition status field, all bits reserved
// - 32-bit millisecond uptime, low half at input 14, high at 15
// - from input 16, N words of first distance per segment, zero if none
// - next N words give first amplitude times 64, zero if none
// - flag word: bit0 always, bit1 demerged, bit3 saturated, bit6 crosstalk
// - detections two to six follow as distance, amplitude, flag arrays
// - each 16-bit word is sent high byte first
// - holding 0 is exponent n giving 2^n accumulations
// - holding 1 is exponent n giving 2^n oversamplings
// - holding 2 is base sample count, holding 3 is reserved
// - holding 4 is threshold with six fraction bits, value over 64
// - exception 2 bad address, 3 bad value, 4 execution failure
package modbus_pkg;
	// ------------------------------------------------------------------------
	// function and exception codes
	// ------------------------------------------------------------------------
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_ONE = 8'h06;
	localparam logic [7:0] FC_WR_MULTI = 8'h10;
	localparam logic [7:0] FC_RW_MULTI = 8'h17;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_FAIL = 8'h04;
	localparam logic [7:0] EXC_MARK = 8'h80;
	localparam logic [7:0] UNIT_BCAST = 8'h00;
	// ------------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------------
	localparam logic [15:0] IR_READY = 16'h0001;
	localparam logic [15:0] IR_SEGS = 16'h0002;
	localparam logic [15:0] IR_DET_COUNT = 16'h000b;
	localparam logic [15:0] IR_LIGHT = 16'h000c;
	localparam logic [15:0] IR_STATUS = 16'h000d;
	localparam logic [15:0] IR_TS_LO = 16'h000e;
	localparam logic [15:0] IR_TS_HI = 16'h000f;
	localparam logic [15:0] IR_ARRAY = 16'h0010;
	localparam logic [15:0] ARRAYS_PER_SEG = 16'h0012;
	localparam logic [15:0] HR_RSVD = 16'h0003;
	localparam logic [15:0] HR_LAST = 16'h0004;
	localparam int HR_COUNT = 5;
	localparam logic [15:0] HR_RST = 16'h0000;
	localparam logic [15:0] STATUS_RSVD = 16'h0000;
	localparam logic [15:0] FLAG_KEEP = 16'hff4a;
	localparam logic [15:0] FLAG_VALID = 16'h0001;
	// ------------------------------------------------------------------------
	// quantity limits, crc and framing
	// ------------------------------------------------------------------------
	localparam logic [15:0] MAX_RD_QTY = 16'h007d;
	localparam logic [15:0] MAX_WR_QTY = 16'h007b;
	localparam logic [15:0] MAX_RW_QTY = 16'h0079;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam int CLK_MHZ = 10;
	localparam int SILENCE_US = 1750;
	localparam int SILENCE_CYCLES = SILENCE_US * CLK_MHZ;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES = MS_US * CLK_MHZ;
	// ------------------------------------------------------------------------
	// server states, gray coded along the read path from idle to crch
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_RECV = 4'h1,
		ST_EXEC = 4'h3,
		ST_HDR = 4'h2,
		ST_FETCH = 4'h6,
		ST_WAIT = 4'h7,
		ST_DHI = 4'h5,
		ST_DLO = 4'h4,
		ST_CRCL = 4'hc,
		ST_CRCH = 4'hd
	} srv_state_t;

	// one byte of the reflected crc-16
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step
endpackage : modbus_pkg

// ==== rtu_master_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// rtu master on the far side of one byte link
// ----------------------------------------------------------------
module rtu_master_model (
	input wire logic clk,
	output logic [7:0] rq_data,
	output logic rq_valid,
	input wire logic [7:0] an_data,
	input wire logic an_valid,
	output logic an_ready
);
	logic [7:0] ans[$];
	int seed = 32'hb191;
	// reflected crc-16 over a byte queue
	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i]) begin
			c = c ^ {8'h00, f[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc16
	// idle link, ready stalls at random
	initial begin
		rq_data = 8'h00;
		rq_valid = 1'b0;
	end
	always @(negedge clk) begin
		an_ready <= ($random(seed) % 4) != 0;
	end
	// answer bytes are taken at the handshake edge
	always @(posedge clk) begin
		if (an_valid && an_ready) begin
			ans.push_back(an_data);
		end
	end
	// rtu frame, crc low byte first; bad flips one crc bit
	task automatic send(input logic [7:0] f[$], input bit bad);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		ans.delete();
		foreach (f[i]) begin
			@(negedge clk);
			rq_data = f[i];
			rq_valid = 1'b1;
			@(negedge clk);
			rq_valid = 1'b0;
			rq_data = ~f[i]; // released line shows no stale byte
		end
	endtask : send
endmodule : rtu_master_model

// ==== modbus_detection_register_server_tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register server bench
// ----------------------------------------------------------------
module modbus_detection_register_server_tb_top;
	import modbus_pkg::*;
	localparam int SIL = 40;
	localparam int MSC = 20;
	localparam logic [7:0] UNIT = 8'h11;
	logic clk, rst_b, det_new, exec_fail;
	logic [7:0] s_rd, s_td, u_rd, u_td;
	logic s_rv, s_tv, s_tr, u_rv, u_tv, u_tr;
	logic [15:0] segs, map_addr, map_data, h0, h1, h2, h4, h0_o, h1_o;
	logic [15:0] h2_o, h4_o;
	logic [7:0] rq[$];
	logic [7:0] an[$];
	logic [15:0] wv[$];
	int n_mismatch, total_checks, seed, a, q;
	rtu_master_model m_ser (.clk(clk), .rq_data(s_rd), .rq_valid(s_rv),
		.an_data(s_td), .an_valid(s_tv), .an_ready(s_tr));
	rtu_master_model m_usb (.clk(clk), .rq_data(u_rd), .rq_valid(u_rv),
		.an_data(u_td), .an_valid(u_tv), .an_ready(u_tr));
	modbus_register_server #(.SILENCE_CYC(SIL), .MS_CYC(MSC)) dut (
		.clk(clk), .rst_b(rst_b), .unit_addr(UNIT), .ser_rx_data(s_rd),
		.ser_rx_valid(s_rv), .ser_tx_data(s_td), .ser_tx_valid(s_tv),
		.ser_tx_ready(s_tr), .usb_rx_data(u_rd), .usb_rx_valid(u_rv),
		.usb_tx_data(u_td), .usb_tx_valid(u_tv), .usb_tx_ready(u_tr),
		.det_new(det_new), .segment_count(segs),
		.detection_count(16'h0005), .light_power_percent(16'h0050),
		.map_addr(map_addr), .map_data(map_data), .exec_fail(exec_fail),
		.accumulation_exponent(h0_o), .oversampling_exponent(h1_o),
		.base_sample_count(h2_o), .detection_threshold(h4_o));
	// clock and detection word source, half a cycle behind map_addr
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		map_data <= mapf(map_addr);
	end
	// detection word pattern and its expected register value
	function automatic logic [15:0] mapf(input logic [15:0] i);
		return {~i[7:0], i[7:0] + 8'h5b};
	endfunction : mapf
	function automatic logic [15:0] arr(input int r);
		logic [15:0] w;
		w = mapf(16'(r - 16));
		if ((r - 16) % (3 * segs) >= 2 * segs) begin
			w = (w & FLAG_KEEP) | FLAG_VALID;
		end
		return w;
	endfunction : arr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	task automatic mk(input logic [7:0] u, input logic [7:0] fc,
		input int a, input int q);
		rq = {u, fc, 8'(a >> 8), 8'(a), 8'(q >> 8), 8'(q)};
	endtask : mk
	task automatic pw(input logic [15:0] w);
		rq.push_back(w[15:8]);
		rq.push_back(w[7:0]);
	endtask : pw
	task automatic grab(input bit usb);
		if (usb) begin
			an = m_usb.ans;
		end else begin
			an = m_ser.ans;
		end
	endtask : grab
	// one request, bounded wait for n answer bytes
	task automatic xfer(input bit usb, input bit bad, input int n);
		int k;
		if (usb) begin
			m_usb.send(rq, bad);
		end else begin
			m_ser.send(rq, bad);
		end
		for (k = 0; k < SIL + 300 + 4 * n; k++) begin
			@(negedge clk);
			grab(usb);
			if (an.size() >= n && k > SIL + 20) break;
		end
		if (k >= SIL + 300 + 4 * n) begin
			n_mismatch++;
			$display("Error %0t: answer timed out", $time);
			finish_test();
		end else begin
			repeat (8) @(negedge clk);
			grab(usb);
			chk(16'(an.size()), 16'(n));
			if (n > 4) chk({an[n-1], an[n-2]}, m_ser.crc16(an[0:n-3]));
			wv.delete();
			for (k = 3; k + 3 < n; k += 2) wv.push_back({an[k], an[k+1]});
		end
	endtask : xfer
	task automatic rd(input bit usb, input logic [7:0] fc, input int a,
		input int q);
		mk(UNIT, fc, a, q);
		xfer(usb, 1'b0, 5 + 2 * q);
		chk({an[1], an[2]}, {fc, 8'(2 * q)});
	endtask : rd
	task automatic ex(input logic [7:0] fc, input int a, input int q,
		input logic [7:0] c);
		mk(UNIT, fc, a, q);
		xfer(1'b0, 1'b0, 5);
		chk({an[1], an[2]}, {fc | EXC_MARK, c});
	endtask : ex
	// main sequence
	initial begin
		seed = 32'hb191;
		n_mismatch = 0;
		total_checks = 0;
		rst_b = 1'b0;
		det_new = 1'b0;
		exec_fail = 1'b0;
		segs = 16'h0008;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		rd(1'b0, FC_RD_HOLD, 0, 5);
		foreach (wv[i]) chk(wv[i], HR_RST);
		det_new = 1'b1;
		@(negedge clk);
		det_new = 1'b0;
		rd(1'b0, FC_RD_INPUT, 1, 2);
		chk(wv[0], 16'h0001);
		chk(wv[1], segs);
		rd(1'b1, FC_RD_INPUT, 1, 1);
		chk(wv[0], 16'h0000);
		a = int'($time / (100 * MSC)) - 2;
		rd(1'b1, FC_RD_INPUT, 11, 5);
		chk(wv[0], 16'h0005);
		chk(wv[1], 16'h0050);
		chk(wv[2], STATUS_RSVD);
		chk(16'({wv[4], wv[3]} - 32'(a) < 32'd16), 16'h0001);
		repeat (8) begin
			segs = 16'(1 + $unsigned($random(seed)) % 8);
			a = 16 + $unsigned($random(seed)) % (18 * segs);
			q = 1 + $unsigned($random(seed)) % 8;
			if (a + q > 16 + 18 * segs) q = 16 + 18 * segs - a;
			rd(a[0], FC_RD_INPUT, a, q);
			foreach (wv[i]) chk(wv[i], arr(a + i));
		end
		rd(1'b0, FC_RD_INPUT, 15 + 18 * segs, 1);
		chk(wv[0], arr(15 + 18 * segs));
		ex(FC_RD_INPUT, 3, 1, EXC_ADDR);
		ex(FC_RD_INPUT, 16 + 18 * segs, 1, EXC_ADDR);
		ex(FC_RD_INPUT, 1, 0, EXC_VALUE);
		ex(FC_RD_HOLD, 4, 2, EXC_ADDR);
		ex(FC_RD_HOLD, 0, 126, EXC_VALUE);
		ex(8'h2b, 0, 1, EXC_FUNC);
		exec_fail = 1'b1;
		ex(FC_RD_INPUT, 1, 1, EXC_FAIL);
		exec_fail = 1'b0;
		h0 = 16'($random(seed));
		h1 = 16'($random(seed));
		h2 = 16'($random(seed));
		h4 = 16'($random(seed));
		mk(UNIT, FC_WR_ONE, 0, h0);
		xfer(1'b0, 1'b0, 8);
		chk({an[4], an[5]}, h0);
		mk(UNIT, FC_WR_MULTI, 1, 4);
		rq.push_back(8'h08);
		pw(h1);
		pw(h2);
		pw(16'hbeef);
		pw(16'h0000);
		xfer(1'b1, 1'b0, 8);
		chk({an[4], an[5]}, 16'h0004);
		mk(UNIT, FC_RW_MULTI, 0, 4);
		pw(16'h0004);
		pw(16'h0001);
		rq.push_back(8'h02);
		pw(h4);
		xfer(1'b0, 1'b0, 13);
		chk(wv[0], h0);
		chk(wv[1], h1);
		chk(wv[3], 16'h0000);
		rd(1'b1, FC_RD_HOLD, 0, 5);
		chk(wv[2], h2);
		chk(wv[4], h4);
		chk(h0_o, h0);
		chk(h1_o, h1);
		chk(h2_o, h2);
		chk(h4_o, h4);
		mk(8'h22, FC_RD_INPUT, 1, 1);
		xfer(1'b0, 1'b0, 0);
		mk(UNIT, FC_RD_INPUT, 1, 1);
		xfer(1'b1, 1'b1, 0);
		mk(UNIT_BCAST, FC_WR_ONE, 4, 16'h0123);
		xfer(1'b0, 1'b0, 0);
		chk(h4_o, 16'h0123);
		finish_test();
	end
endmodule : modbus_detection_register_server_tb_top
